/* count_source.sv */
// Count clock source standing in for the clock controller.
// Assumes the bench raises run once the watchdog may count.
`timescale 1ns/1ps
module count_source (
    input  wire logic run,
    output logic      count_clock
);
    // ****************************************
    // Clock generation
    // ****************************************
    // clock set up outside
    initial begin
        count_clock = 1'b0;
        forever begin
            #80;
            if (run) begin
                count_clock = ~count_clock;
            end else begin
                count_clock = 1'b0; // Stands still when gated
            end
        end
    end
endmodule : count_source

/* tb_top.sv */
// Self-checking bench for the windowed watchdog.
// Assumes count_source makes the 160 ns count clock.
`timescale 1ns/1ps
module tb_top;
    import watchdog_pkg::*;
    logic        sys_clk;
    logic        reset_n;
    logic        debugger_access;
    logic        debug_halt;
    logic        protect_lock;
    logic        run;
    bus_req_t    bus_req;
    logic [31:0] bus_rdata;
    logic        count_clock;
    logic        irq;
    logic        system_reset_req;
    logic [31:0] v;
    logic [31:0] r;
    int          fail_count;
    int          tests_run;
    int          seed;

    // ****************************************
    // Parts
    // ****************************************
    count_source src (.run(run), .count_clock(count_clock));
    watchdog_unit dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req),
        .debugger_access(debugger_access), .bus_rdata(bus_rdata),
        .count_clock(count_clock), .debug_halt(debug_halt),
        .protect_lock(protect_lock), .irq(irq),
        .system_reset_req(system_reset_req));

    // bus clock runs from reset on
    always #10 sys_clk = ~sys_clk;

    // ****************************************
    // Tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    task hold(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : hold

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge sys_clk);
        bus_req.write <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
        @(posedge sys_clk);
        bus_req.read <= 1'b0;
        #1;
        chk(bus_rdata, e);
    endtask : rdc

    // Bounded wait on irq (sel 1) or reset request (sel 0)
    task wait_out(input bit sel, input int n);
        int i;
        tests_run++;
        for (i = 0; i < n; i++) begin
            hold(1);
            if ((sel ? irq : system_reset_req) === 1'b1) return;
        end
        fail_count++;
        $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
        tally_and_finish();
    endtask : wait_out

    task rst;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : rst

    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        debugger_access = 1'b0;
        debug_halt = 1'b0;
        protect_lock = 1'b0;
        run = 1'b1;
        bus_req = '0;
        fail_count = 0;
        tests_run = 0;
        seed = 83547;
        rst();
        rdc(CTRL_OFS, 32'h0);
        rdc(CONFIG_OFS, 32'hbb);
        rdc(EARLY_WARNING_CTRL_REG_OFS, 32'hb);
        rdc(INTEN_OFS, 32'h0);
        rdc(8'h1c, 32'h0);
        repeat (4) begin
            v = $random(seed);
            wr(CONFIG_OFS, v);
            rdc(CONFIG_OFS, {24'h0, v[7:0]});
        end
        $display("test reset values done");
        // Shortest period, serviced in time, then starved
        wr(CONFIG_OFS, 32'h0);
        wr(CTRL_OFS, 32'h1);
        hold(40);
        chk(system_reset_req, 1'b0);
        repeat (6) begin
            wr(SERVICE_OFS, 32'ha5);
            hold(30);
        end
        chk(system_reset_req, 1'b0);
        wait_out(1'b0, 120);
        $display("test normal time-out done");
        rst();
        repeat (3) begin
            v = $random(seed);
            if (v[7:0] == 8'ha5) v[7:0] = 8'h5a;
            wr(CTRL_OFS, 32'h1);
            wr(SERVICE_OFS, v);
            hold(2);
            chk(system_reset_req, 1'b1);
            rst();
        end
        $display("test wrong key done");
        // Early warning at 8 ticks, time-out at 16
        wr(CONFIG_OFS, 32'h1);
        wr(EARLY_WARNING_CTRL_REG_OFS, 32'h0);
        wr(INTEN_OFS, 32'h1);
        wr(CTRL_OFS, 32'h1);
        wait_out(1'b1, 100);
        chk(system_reset_req, 1'b0);
        hold(20);
        chk(irq, 1'b1);
        wr(IFLAG_OFS, 32'h1);
        rdc(IFLAG_OFS, 32'h0);
        chk(irq, 1'b0);
        wr(CTRL_OFS, 32'h0);
        rdc(CTRL_OFS, 32'h0);
        hold(200);
        chk(system_reset_req, 1'b0);
        $display("test early warning done");
        wr(CTRL_OFS, 32'h4);
        wr(CTRL_OFS, 32'h5);
        wr(CONFIG_OFS, 32'h11);
        rdc(CONFIG_OFS, 32'h1);
        wr(CTRL_OFS, 32'h0);
        rdc(CTRL_OFS, 32'h5);
        wr(CTRL_OFS, 32'h7);
        rdc(CTRL_OFS, 32'h5);
        $display("test enable lock done");
        rst();
        // Access protection, debugger bypass, debug halt
        @(posedge sys_clk);
        protect_lock <= 1'b1;
        wr(CONFIG_OFS, 32'h22);
        rdc(CONFIG_OFS, 32'hbb);
        wr(INTEN_OFS, 32'h1);
        rdc(INTEN_OFS, 32'h0);
        debugger_access <= 1'b1;
        wr(CONFIG_OFS, 32'h33);
        debugger_access <= 1'b0;
        rdc(CONFIG_OFS, 32'h33);
        debug_halt <= 1'b1;
        hold(4);
        wr(CONFIG_OFS, 32'h0);
        rdc(CONFIG_OFS, 32'h0);
        wr(CTRL_OFS, 32'h1);
        hold(200);
        chk(system_reset_req, 1'b0);
        rdc(STATUS_OFS, 32'h0);
        debug_halt <= 1'b0;
        protect_lock <= 1'b0;
        run <= 1'b0;
        hold(200);
        chk(system_reset_req, 1'b0);
        run <= 1'b1;
        wait_out(1'b0, 150);
        $display("test protection and halt done");
        rst();
        // Window: too early, then in time, then late
        wr(CTRL_OFS, 32'h2);
        wr(CONFIG_OFS, 32'h0);
        wr(CTRL_OFS, 32'h3);
        hold(20);
        wr(SERVICE_OFS, 32'ha5);
        wait_out(1'b0, 100);
        rst();
        wr(CTRL_OFS, 32'h2);
        wr(CONFIG_OFS, 32'h0);
        wr(CTRL_OFS, 32'h3);
        hold(84);
        wr(SERVICE_OFS, 32'ha5);
        hold(20);
        chk(system_reset_req, 1'b0);
        wait_out(1'b0, 200);
        $display("test window mode done");
        tally_and_finish();
    end
endmodule : tb_top

/* watchdog_pkg.sv */
// Constants, register map and state types for the windowed watchdog.
// Assumes one system clock and a slow, free count clock sampled by it.
//
// How it works
// R1: Enabled counter runs; service restarts period
// R2: Missed service before time-out resets system
// R3: Optional early-warning interrupt before time-out
// R4: Window mode: service outside window resets
// R5: Periods 8..16k cycles, window 8..16k
// R6: Keeps counting whenever count clock runs, unless disabled or in debug halt
// R7: Counts on processor-independent count clock
// R8: Interrupt line usable as wake source
// R9: Bus clock on after reset, gateable
// R10: Count clock set up by clock controller
// R11: Cross-domain accesses synchronised before effect
// R12: Single interrupt request line out
// R13: Debug halt suspends counting
// R14: Writes lockable except interrupt flag register
// R15: Debug halt lifts write protection
// R16: External debugger writes bypass protection
// R17: Key 0xa5 services; other value resets
// R18: Mode from enable, window and warning bits
// R19: Protected fields ignore writes while enabled
// R20: Keep-running lock blocks disabling
// R21: Warning flag sticky until one written
package watchdog_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL_OFS    = 8'h00; // Enable, window, lock
    localparam logic [7:0] CONFIG_OFS  = 8'h04; // Period and window codes
    localparam logic [7:0] EARLY_WARNING_CTRL_REG_OFS  = 8'h08; // Early-warning offset
    localparam logic [7:0] INTEN_OFS   = 8'h0c; // Interrupt enable
    localparam logic [7:0] IFLAG_OFS   = 8'h10; // Interrupt flag
    localparam logic [7:0] SERVICE_OFS = 8'h14; // Service key
    localparam logic [7:0] STATUS_OFS  = 8'h18; // Count and sync state

    // ****************************************
    // Field positions and values
    // ****************************************
    localparam int CTRL_ENABLE_BIT  = 0;  // Enable
    localparam int CTRL_WINDOW_BIT  = 1;  // Window mode enable
    localparam int CTRL_KEEP_BIT    = 2;  // Keep-running lock
    localparam int CONFIG_PER_LSB   = 0;  // Period code [3:0]
    localparam int CONFIG_WIN_LSB   = 4;  // Window code [7:4]
    localparam int EW_BIT           = 0;  // Early-warning bit
    localparam int STATUS_BUSY_BIT  = 0;  // Service awaiting sync
    localparam int STATUS_OPEN_BIT  = 1;  // Window open
    localparam int STATUS_CNT_LSB   = 16; // Count [31:16]

    localparam logic [7:0]  SERVICE_KEY  = 8'ha5; // Valid service key
    localparam logic [15:0] BASE_LEN     = 16'h0008; // Shortest period
    localparam logic [3:0]  CODE_MAX     = 4'hb; // Twelve period codes
    localparam logic [3:0]  PER_RESET    = 4'hb; // Period code at reset
    localparam logic [3:0]  WIN_RESET    = 4'hb; // Window code at reset
    localparam logic [3:0]  EWOFF_RESET  = 4'hb; // Warning code at reset

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [7:0]  addr;  // Byte address
        logic [31:0] wdata; // Write data
        logic        write; // Write strobe
        logic        read;  // Read strobe
    } bus_req_t;

    typedef struct packed {
        logic        enable;   // Counter enabled
        logic        win_en;   // Window mode
        logic        keep;     // Keep-running lock
        logic [3:0]  per;      // Period code
        logic [3:0]  win;      // Closed-window code
        logic [3:0]  ewoff;    // Warning offset code
        logic        ew_ie;    // Warning interrupt enable
        logic        ew_flag;  // Warning flag
        logic [15:0] cnt;      // Count-clock cycles
        logic        open;     // Window open phase
        logic        svc_pend; // Service waiting for a tick
        logic        sys_rst;  // System reset request
        logic [31:0] rdata;    // Read data
        logic        cc1;      // Count clock sync stage 1
        logic        cc2;      // Count clock sync stage 2
        logic        cc3;      // Count clock edge history
        logic        dbg1;     // Debug halt sync stage 1
        logic        dbg2;     // Debug halt sync stage 2
    } state_t;

endpackage : watchdog_pkg

/* watchdog_unit.sv */
// Windowed watchdog: register slave, count-clock edge finder, counter.
// Assumes a plain register port on sys_clk and an external reset block
// that acts on system_reset_req.
`timescale 1ns/1ps
module watchdog_unit (
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    input  wire watchdog_pkg::bus_req_t bus_req,
    input  wire logic                  debugger_access,
    output logic [31:0]                bus_rdata,
    input  wire logic                  count_clock,
    input  wire logic                  debug_halt,
    input  wire logic                  protect_lock,
    output logic                       irq,
    output logic                       system_reset_req
);
    import watchdog_pkg::*;

    // ****************************************
    // Decode helper
    // ****************************************
    // Period length for a code: base doubled per step, capped
    function automatic logic [15:0] period_len(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code;
        period_len = BASE_LEN << c;
    endfunction : period_len

    state_t st_reg;  // All state
    state_t st_next; // Next state
    logic   rst_s1;  // Reset release stage 1
    logic   rst_n_s; // Synchronised reset

    // ****************************************
    // Reset release
    // ****************************************
    // Asserts at once, releases after two edges
    // Keeps a late release edge from racing the state flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1  <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_s1  <= 1'b1;
            rst_n_s <= rst_s1;
        end
    end

    // ****************************************
    // Combinational helpers
    // ****************************************
    logic        tick;      // Count-clock rising edge
    logic        halted;    // Debug halt, synchronised
    logic        locked;    // Write protection in force
    logic        wr_ok;     // Protected write allowed
    logic [15:0] cnt_inc;   // Count plus one
    logic [15:0] per_len;   // Open/normal period length
    logic [15:0] win_len;   // Closed window length
    logic [15:0] ew_len;    // Warning point
    logic        wr_ctrl;   // Write to control
    logic        wr_cfg;    // Write to configuration
    logic        wr_ew;     // Write to warning control
    logic        wr_svc;    // Write to service register
    logic        closed;    // Window mode, window not yet open

    always_comb begin
        halted  = st_reg.dbg2;
        tick    = st_reg.cc2 & ~st_reg.cc3;
        // R15 halt unlocks
        // R16 debugger bypasses lock
        locked  = protect_lock & ~halted & ~debugger_access;
        // R14 protection gate
        wr_ok   = bus_req.write & ~locked;
        wr_ctrl = wr_ok && (bus_req.addr == CTRL_OFS);
        wr_cfg  = wr_ok && (bus_req.addr == CONFIG_OFS);
        wr_ew   = wr_ok && (bus_req.addr == EARLY_WARNING_CTRL_REG_OFS);
        wr_svc  = wr_ok && (bus_req.addr == SERVICE_OFS);
        cnt_inc = st_reg.cnt + 16'h0001;
        per_len = period_len(st_reg.per);
        win_len = period_len(st_reg.win);
        ew_len  = period_len(st_reg.ewoff);
        closed  = st_reg.win_en & ~st_reg.open;
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        st_next = st_reg;
        // Two-stage samplers, edge history
        st_next.cc1  = count_clock;
        st_next.cc2  = st_reg.cc1;
        st_next.cc3  = st_reg.cc2;
        st_next.dbg1 = debug_halt;
        st_next.dbg2 = st_reg.dbg1;

        // R18 control bits select mode
        if (wr_ctrl) begin
            // R20 lock keeps it running
            if (bus_req.wdata[CTRL_ENABLE_BIT] || !st_reg.keep) begin
                st_next.enable = bus_req.wdata[CTRL_ENABLE_BIT];
            end
            // R19 fields frozen while enabled
            if (!st_reg.enable) begin
                st_next.win_en = bus_req.wdata[CTRL_WINDOW_BIT];
                st_next.keep   = bus_req.wdata[CTRL_KEEP_BIT];
            end
            // Fresh start on enabling
            if (!st_reg.enable) begin
                st_next.cnt  = 16'h0000;
                st_next.open = 1'b0;
            end
        end
        // R19 configuration frozen while enabled
        if (wr_cfg && !st_reg.enable) begin
            st_next.per = bus_req.wdata[CONFIG_PER_LSB +: 4];
            st_next.win = bus_req.wdata[CONFIG_WIN_LSB +: 4];
        end
        if (wr_ew && !st_reg.enable) begin
            st_next.ewoff = bus_req.wdata[3:0];
        end
        if (wr_ok && bus_req.addr == INTEN_OFS) begin
            st_next.ew_ie = bus_req.wdata[EW_BIT];
        end

        // R21 write one clears flag
        if (bus_req.write && bus_req.addr == IFLAG_OFS
            && bus_req.wdata[EW_BIT]) begin
            st_next.ew_flag = 1'b0;
        end

        // A second key landing on the applying tick folds into that
        // restart rather than queuing; the period starts over either way
        // R17 key check on service
        if (wr_svc && st_reg.enable) begin
            if (bus_req.wdata[7:0] == SERVICE_KEY) begin
                st_next.svc_pend = 1'b1;
            end else begin
                st_next.sys_rst = 1'b1;
            end
        end

        // R1 R6 R7 counting on count-clock edges
        // R13 halt freezes counter
        if (st_reg.enable && !halted && tick) begin
            st_next.cnt = cnt_inc;
            // R11 service applied on synced tick
            if (st_reg.svc_pend) begin
                st_next.svc_pend = 1'b0;
                st_next.cnt      = 16'h0000;
                st_next.open     = 1'b0;
                // R4 early service resets
                if (closed) begin
                    st_next.sys_rst = 1'b1;
                end
            end else if (closed) begin
                // R5 closed phase length
                if (cnt_inc == win_len) begin
                    st_next.open = 1'b1;
                    st_next.cnt  = 16'h0000;
                end
            end else begin
                // R3 warning point reached
                if (cnt_inc == ew_len && !st_reg.win_en) begin
                    st_next.ew_flag = 1'b1;
                end
                if (cnt_inc == ew_len && st_reg.win_en) begin
                    st_next.ew_flag = 1'b1;
                end
                // R2 R4 late: period expired
                if (cnt_inc == per_len) begin
                    st_next.sys_rst = 1'b1;
                    st_next.cnt     = 16'h0000;
                end
            end
        end
        if (!st_reg.enable) begin
            st_next.svc_pend = 1'b0;
        end

        // Read data, one cycle after the strobe
        st_next.rdata = 32'h0000_0000;
        if (bus_req.read) begin
            if (bus_req.addr == CTRL_OFS) begin
                st_next.rdata[CTRL_ENABLE_BIT] = st_reg.enable;
                st_next.rdata[CTRL_WINDOW_BIT] = st_reg.win_en;
                st_next.rdata[CTRL_KEEP_BIT]   = st_reg.keep;
            end else if (bus_req.addr == CONFIG_OFS) begin
                st_next.rdata[CONFIG_PER_LSB +: 4] = st_reg.per;
                st_next.rdata[CONFIG_WIN_LSB +: 4] = st_reg.win;
            end else if (bus_req.addr == EARLY_WARNING_CTRL_REG_OFS) begin
                st_next.rdata[3:0] = st_reg.ewoff;
            end else if (bus_req.addr == INTEN_OFS) begin
                st_next.rdata[EW_BIT] = st_reg.ew_ie;
            end else if (bus_req.addr == IFLAG_OFS) begin
                st_next.rdata[EW_BIT] = st_reg.ew_flag;
            end else if (bus_req.addr == STATUS_OFS) begin
                st_next.rdata[STATUS_BUSY_BIT] = st_reg.svc_pend;
                st_next.rdata[STATUS_OPEN_BIT] = st_reg.open;
                st_next.rdata[STATUS_CNT_LSB +: 16] = st_reg.cnt;
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // R9 registers clocked by the bus clock
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            st_reg       <= '0;
            st_reg.per   <= PER_RESET;
            st_reg.win   <= WIN_RESET;
            st_reg.ewoff <= EWOFF_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // R8 R12 one level line, usable for wake
    assign irq              = st_reg.ew_flag & st_reg.ew_ie;
    assign system_reset_req = st_reg.sys_rst;
    assign bus_rdata        = st_reg.rdata;

    // ****************************************
    // Checks
    // ****************************************
    chk_bad_key: assert property ( // R17
        @(posedge sys_clk) disable iff (!rst_n_s)
        (wr_svc && st_reg.enable && bus_req.wdata[7:0] != SERVICE_KEY)
        |=> system_reset_req)
        else $error("bad service key gave no reset");

    chk_period_end: assert property ( // R2
        @(posedge sys_clk) disable iff (!rst_n_s)
        (st_reg.enable && !halted && tick && !st_reg.svc_pend && !closed
         && cnt_inc == per_len) |=> system_reset_req)
        else $error("time-out gave no reset");

    chk_early_warn: assert property ( // R3
        @(posedge sys_clk) disable iff (!rst_n_s)
        (st_reg.enable && !halted && tick && !st_reg.svc_pend && !closed
         && cnt_inc == ew_len) |=> st_reg.ew_flag)
        else $error("warning flag not raised");

    chk_early_svc: assert property ( // R4
        @(posedge sys_clk) disable iff (!rst_n_s)
        (st_reg.enable && !halted && tick && st_reg.svc_pend && closed)
        |=> system_reset_req)
        else $error("early service gave no reset");

    chk_halt_freeze: assert property ( // R13
        @(posedge sys_clk) disable iff (!rst_n_s)
        (halted && st_reg.enable && !wr_ctrl) |=> $stable(st_reg.cnt))
        else $error("counter moved during halt");

    chk_cfg_frozen: assert property ( // R19
        @(posedge sys_clk) disable iff (!rst_n_s)
        (st_reg.enable && wr_cfg) |=> $stable(st_reg.per))
        else $error("config changed while enabled");

    chk_keep_on: assert property ( // R20
        @(posedge sys_clk) disable iff (!rst_n_s)
        (st_reg.enable && st_reg.keep) |=> st_reg.enable)
        else $error("locked watchdog was disabled");

    chk_flag_sticky: assert property ( // R21
        @(posedge sys_clk) disable iff (!rst_n_s)
        (st_reg.ew_flag && !(bus_req.write && bus_req.addr == IFLAG_OFS))
        |=> st_reg.ew_flag)
        else $error("warning flag dropped by itself");

    chk_locked_wr: assert property ( // R14
        @(posedge sys_clk) disable iff (!rst_n_s)
        (bus_req.write && locked && bus_req.addr == INTEN_OFS)
        |=> $stable(st_reg.ew_ie))
        else $error("protected write took effect");

    chk_good_key: assert property ( // R17
        @(posedge sys_clk) disable iff (!rst_n_s)
        (wr_svc && st_reg.enable && !st_reg.svc_pend
         && bus_req.wdata[7:0] == SERVICE_KEY) |=> st_reg.svc_pend)
        else $error("valid key left no service pending");

    chk_ctrl_frozen: assert property ( // R19
        @(posedge sys_clk) disable iff (!rst_n_s)
        (st_reg.enable && wr_ctrl) |=> $stable(st_reg.win_en))
        else $error("window bit changed while enabled");

    chk_stopped_idle: assert property ( // R18
        @(posedge sys_clk) disable iff (!rst_n_s)
        (!st_reg.enable && !wr_ctrl) |=> $stable(st_reg.cnt))
        else $error("counter moved while stopped");

    chk_disable_ok: assert property ( // R20
        @(posedge sys_clk) disable iff (!rst_n_s)
        (wr_ctrl && !st_reg.keep && !bus_req.wdata[CTRL_ENABLE_BIT])
        |=> !st_reg.enable)
        else $error("unlocked watchdog not disabled");

endmodule : watchdog_unit
